// File: tb/ilo_mem_model.sv
/* data memory behind ilo_exec; byte valid in read pulse and next cycle */
`timescale 1ns/1ps
module ilo_mem_model
	import ilo_pkg::*;
(
	input wire logic     clk,
	input wire mem_req_t mem_req,
	output logic [7:0]   mem_rdata
);
	logic [7:0] mem [4096];
	logic       rd_q = 1'b0;
	logic [7:0] last_q = 8'h00;
	always @(posedge clk)
	begin
		rd_q <= mem_req.rd;
		if (mem_req.wr)
			mem[mem_req.addr] <= mem_req.wdata;
		if (mem_req.rd | rd_q)
			last_q <= mem[mem_req.addr];
	end
	assign mem_rdata = (mem_req.rd | rd_q) ? mem[mem_req.addr] : ~last_q;
endmodule : ilo_mem_model

// File: tb/ilo_monitor.sv
/* port checker of ilo_exec; assumes the bind at the foot */
`timescale 1ns/1ps
module ilo_monitor
	import ilo_pkg::*;
(
	input wire logic        clk,
	input wire logic        rstn,
	input wire logic        extended_set_config_bit,
	input wire logic [11:0] stack_frame_pointer,
	input wire logic [15:0] instr_word,
	input wire mem_req_t    mem_req,
	input wire status_t     status,
	input wire logic        instr_done
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	logic [7:0] k;
	assign k = instr_word[7:0];
	rd_to_done_a: assert property (mem_req.rd |-> ##3 instr_done) else $error("late done");
	addr_form_a: assert property (mem_req.rd |->
		mem_req.addr == stack_frame_pointer + {4'h0, k}) else $error("bad address");
	cfg_gate_a: assert property (mem_req.rd |-> extended_set_config_bit) else $error("index off");
	offset_lim_a: assert property (mem_req.rd |-> k < 8'h5F) else $error("offset too big");
	abit_gate_a: assert property (mem_req.rd |-> !instr_word[8]) else $error("a bit set");
	set_all_data_a: assert property (mem_req.wr && instr_word[15:8] == 8'h68 |->
		mem_req.wdata == 8'hFF && $stable(status)) else $error("set-all bad");
	bit_set_data_a: assert property (mem_req.wr && instr_word[15:12] == 4'h8 |->
		mem_req.wdata[instr_word[11:9]] && $stable(status)) else $error("bit set bad");
	add_dest_a: assert property ($past(mem_req.rd, 3) && instr_word[15:9] == 7'h12 |->
		!mem_req.wr) else $error("add wrote memory");
	done_pulse_a: assert property (instr_done |=> !instr_done) else $error("long done");
	cover property (mem_req.wr && instr_word[15:12] == 4'h8);
	cover property (mem_req.wr && instr_word[15:8] == 8'h68);
	cover property (mem_req.wr && instr_word[15:10] == 6'h09);
endmodule : ilo_monitor
bind ilo_exec ilo_monitor mon (.clk, .rstn, .extended_set_config_bit, .stack_frame_pointer,
	.instr_word, .mem_req, .status, .instr_done);

// File: tb/testbench.sv
/* random indexed and non-indexed traffic into ilo_exec; assumes ilo_mem_model */
`timescale 1ns/1ps
module testbench;
	import ilo_pkg::*;
	typedef struct {logic [7:0] w; status_t s; logic [11:0] a; logic [7:0] m; logic h;} note_t;
	logic        clk = 0, rstn = 0, cfg = 0, valid = 0, done, a, d, hit, ihit;
	logic [11:0] ptr = 12'h000, ad;
	logic [15:0] word = 16'h0000, r, s, lfsr = 16'hDB5A;
	logic [7:0]  rdata, work, k, m, ew = 8'h00;
	logic [8:0]  sum;
	logic [2:0]  b;
	mem_req_t    req;
	status_t     st, es = 5'h00;
	note_t       q[$];
	int          bad_count = 0, checks = 0, i;
	ilo_exec uut (.clk, .rstn, .extended_set_config_bit(cfg), .stack_frame_pointer(ptr), .instr_valid(valid),
		.instr_word(word), .mem_rdata(rdata), .mem_req(req), .work_reg(work), .status(st), .indexed_hit(ihit),
		.instr_done(done));
	ilo_mem_model mem_i (.clk, .mem_req(req), .mem_rdata(rdata));
	function automatic logic [15:0] rnd();
		lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		return lfsr;
	endfunction : rnd
	task automatic chk(string n, logic [7:0] e, logic [7:0] g);
		checks++;
		if (e !== g)
		begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task final_report();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : final_report
	initial forever #4 clk = ~clk;
	initial
	begin
		#100000;
		bad_count++;
		$display("[FAIL] watchdog expected finish seen timeout");
		final_report();
	end
	always @(negedge clk) if (done === 1'b1)
	begin
		note_t n;
		n = q.pop_front();
		chk("work", n.w, work);
		chk("status", n.s, st);
		chk("hit", n.h, ihit);
		chk("memory", n.m, (req.wr === 1'b1 && req.addr === n.a) ? req.wdata : mem_i.mem[n.a]);
	end
	initial
	begin
		repeat (6) @(posedge clk);
		#1 rstn = 1;
		repeat (300)
		begin
			@(posedge clk);
			#1 r = rnd();
			s = rnd();
			k = (r[3:2] == 0) ? 8'h5E + r[4] : s[7:0];
			a = r[5] & r[6];
			d = r[12];
			b = r[11:9];
			cfg = r[7] | r[8];
			ptr = rnd() >> 4;
			m = s[15:8];
			ad = ptr + {4'h0, k};
			mem_i.mem[ad] = m;
			hit = cfg && !a && k < 8'h5F && r[1:0] != 0;
			word = r[1:0] == 1 ? {6'h09, d, a, k} : r[1:0] == 2 ? {4'h8, b, a, k} :
				r[1:0] == 3 ? {7'h34, a, k} : {8'h00, k};
			sum = ew + m;
			if (hit && r[1:0] == 1)
			begin
				es = {sum[7], ew[7] == m[7] && sum[7] != ew[7], sum[7:0] == 0, ew[3:0] + m[3:0] > 5'hF, sum[8]};
				if (d) m = sum[7:0];
				else ew = sum[7:0];
			end
			if (hit && r[1:0] == 2) m[b] = 1'b1;
			if (hit && r[1:0] == 3) m = 8'hFF;
			q.push_back('{ew, es, ad, m, hit});
			valid = 1;
			i = 0;
			while (i < 10)
			begin
				@(posedge clk);
				#1 if (done === 1'b1) break;
				i++;
			end
			if (i == 10)
			begin
				bad_count++;
				$display("[FAIL] done expected 1 seen 0");
			end
			valid = 0;
		end
		repeat (3) @(posedge clk);
		final_report();
	end
endmodule : testbench

// File: verilog/ilo_alu.sv
/*
 combinational add, bit set and set-all for one data byte.
 assumes operands are stable during the process phase.
*/
`timescale 1ns/1ps
`include "ilo_params.svh"

module ilo_alu
	import ilo_pkg::*;
(
	// operation
	input  wire op_t     op,
	input  wire logic [2:0] bit_sel,
	// operands
	input  wire logic [7:0] work,
	input  wire logic [7:0] data,
	// result
	output logic [7:0]      result,
	output status_t         flags
);

	logic [8:0] sum;
	logic [4:0] low;

	always_comb
	begin
		sum    = {1'b0, work} + {1'b0, data};
		low    = {1'b0, work[3:0]} + {1'b0, data[3:0]};
		result = data;
		flags  = '0;
		case (op)
			OP_ADD:
			begin
				result                 = sum[7:0];                                  // [RL3]
				flags.carry_flag       = sum[8];                                    // [RL5]
				flags.digit_carry_flag = low[4];                                    // [RL5]
				flags.zero_flag        = (sum[7:0] == 8'h00);                       // [RL5]
				flags.negative_flag    = sum[7];                                    // [RL5]
				flags.overflow_flag    = (work[7] == data[7]) && (sum[7] != work[7]); // [RL5]
			end
			OP_BIT_SET: result = data | (8'h01 << bit_sel);                     // [RL6]
			OP_SET_ALL: result = `ILO_ALL_ONES;                                   // [RL7]
			default: result = data;
		endcase
	end

endmodule : ilo_alu

// File: verilog/ilo_exec.sv
/*
 indexed literal offset executor: decodes the indexed add, bit set and
 set-all forms, forms the operand address from the stack-frame pointer and
 runs each accepted instruction through decode, read, process and write.
 anything not indexed is answered with instr_done one cycle after it is
 taken, with no memory access; the literal path belongs to the core.
 assumes a data memory that answers a read within one phase, and a core
 that holds instr_valid with the word until instr_done.
 assumes extended_set_config_bit and stack_frame_pointer come from logic
 on this clock and stay steady while an instruction runs.
 mem_req.rd and mem_req.wr are one-cycle pulses; address and write data
 hold until the next request.
*/
`timescale 1ns/1ps
`include "ilo_params.svh"

module ilo_exec
	import ilo_pkg::*;
(
	// clock and reset
	input  wire  logic        clk,
	input  wire  logic        rstn,
	// configuration
	input  wire  logic        extended_set_config_bit,
	input  wire  logic [11:0] stack_frame_pointer,
	// instruction
	input  wire  logic        instr_valid,
	input  wire  logic [15:0] instr_word,
	// data memory
	input  wire  logic [7:0]  mem_rdata,
	output mem_req_t          mem_req,
	// results
	output logic [7:0]        work_reg,
	output status_t           status,
	output logic              indexed_hit,
	output logic              instr_done
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed
	{
		phase_t      phase;
		op_t         op;
		logic        dest;
		logic [2:0]  bit_sel;
		logic [7:0]  data;
		logic [7:0]  result;
		status_t     flags;
		mem_req_t    req;
		logic [7:0]  work;
		status_t     stat;
		logic        hit;
		logic        done;
	} state_t;

	state_t     s_q;
	state_t     s_d;
	logic [7:0] alu_result;
	status_t    alu_flags;
	op_t        dec_op;
	logic       is_idx;
	logic       match_add;
	logic       match_bit_set;
	logic       match_set_all;
	logic       offset_ok;
	logic       dec_dest;
	logic [2:0] dec_bit;
	logic [11:0] idx_addr;

	// ----------------------------------------
	// datapath
	// ----------------------------------------
	ilo_alu u_alu
	(
		.op      (s_q.op),
		.bit_sel (s_q.bit_sel),
		.work    (s_q.work),
		.data    (s_q.data),
		.result  (alu_result),
		.flags   (alu_flags)
	);

	// ----------------------------------------
	// decode
	// ----------------------------------------
	always_comb
	begin
		match_add     = (instr_word[15:10] == `ILO_OP_ADD_HI) && !instr_word[8];    // [RL3]
		match_bit_set = (instr_word[15:12] == `ILO_OP_BITSET_HI) && !instr_word[8]; // [RL6]
		match_set_all = (instr_word[15:8] == `ILO_OP_SETALL_HI);                    // [RL7]
		offset_ok     = (instr_word[7:0] < `ILO_IDX_LIMIT);                          // [RL1]
		dec_dest      = instr_word[9];                                               // [RL4]
		dec_bit       = instr_word[11:9];                                            // [RL6]
		idx_addr      = stack_frame_pointer + {4'h0, instr_word[7:0]};               // [RL1] [RL9]
		dec_op        = OP_NONE;
		if (match_add)
			dec_op = OP_ADD;
		else if (match_bit_set)
			dec_op = OP_BIT_SET;
		else if (match_set_all)
			dec_op = OP_SET_ALL;
		// a=0 in bit 8, operand below limit, extension on
		is_idx = extended_set_config_bit                         // [RL8]
			&& !instr_word[8]                                    // [RL2]
			&& offset_ok;                                        // [RL1]
	end

	// ----------------------------------------
	// phase machine
	// ----------------------------------------
	always_comb
	begin
		s_d          = s_q;
		s_d.req.rd   = 1'b0;
		s_d.req.wr   = 1'b0;
		s_d.done     = 1'b0;
		case (s_q.phase)
			PH_DECODE:
			begin
				if (instr_valid && dec_op != OP_NONE && is_idx)
				begin
					s_d.op      = dec_op;
					s_d.dest    = dec_dest;
					s_d.bit_sel = dec_bit;
					s_d.hit     = 1'b1;
					s_d.req.addr = idx_addr;                             // [RL1]
					s_d.req.rd  = 1'b1;
					s_d.phase   = PH_READ;                           // [RL9]
				end
				else
				begin
					s_d.op   = OP_NONE;
					s_d.hit  = 1'b0;
					s_d.done = instr_valid;
				end
			end

			PH_READ:
			begin
				s_d.data  = mem_rdata;
				s_d.phase = PH_PROCESS;                              // [RL9]
			end

			PH_PROCESS:
			begin
				s_d.result = alu_result;
				if (s_q.op == OP_ADD)
					s_d.flags = alu_flags;                           // [RL5]
				else
					s_d.flags = s_q.stat;                            // [RL6] [RL7]
				s_d.phase  = PH_WRITE;                               // [RL9]
			end

			PH_WRITE:
			begin
				case (s_q.op)
					OP_ADD:
					begin
						s_d.stat = s_q.flags;                        // [RL5]
						if (s_q.dest)
						begin
							s_d.req.wr    = 1'b1;                    // [RL4]
							s_d.req.wdata = s_q.result;
						end
						else
							s_d.work = s_q.result;                   // [RL4]
					end
					OP_BIT_SET:
					begin
						s_d.req.wr    = 1'b1;                        // [RL6]
						s_d.req.wdata = s_q.result;
					end
					OP_SET_ALL:
					begin
						s_d.req.wr    = 1'b1;                        // [RL7]
						s_d.req.wdata = s_q.result;
					end
					default: s_d.req.wr = 1'b0;
				endcase
				s_d.done  = 1'b1;
				s_d.phase = PH_DECODE;                               // [RL9]
			end

			default: s_d.phase = PH_DECODE;
		endcase
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			s_q       <= '0;
			s_q.hit   <= 1'b0;
			s_q.done  <= 1'b0;
			s_q.phase <= PH_DECODE;
			s_q.op    <= OP_NONE;
			s_q.work  <= `ILO_W_RST;
			s_q.stat  <= `ILO_STATUS_RST;
		end
		else
			s_q <= s_d;
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign mem_req     = s_q.req;
	assign work_reg    = s_q.work;
	assign status      = s_q.stat;
	assign indexed_hit = s_q.hit;
	assign instr_done  = s_q.done;

endmodule : ilo_exec

// File: verilog/ilo_params.svh
/*
 constants of the indexed literal offset executor: opcodes, thresholds, reset values.
 assumes a core that presents one 16-bit instruction word per instruction cycle.
*/
// Operation
// [RL1] with the extension on, an access-bank operand below 5Fh is an offset added to the stack-frame pointer.
// [RL2] indexing applies only when the access-bank select bit is 0 and the extension is on, else the operand is literal.
// [RL3] the indexed add (0010 01d0 kkkk kkkk) adds the working register to the byte at pointer plus offset.
// [RL4] the indexed add writes the sum to the working register when d is 0 and back to memory when d is 1.
// [RL5] the indexed add updates negative, overflow, carry, digit carry and zero flags from its result.
// [RL6] the indexed bit set (1000 bbb0 kkkk kkkk) sets bit b of the byte at pointer plus offset, others kept.
// [RL7] the indexed set-all (0110 1000 kkkk kkkk) writes FFh to the byte at pointer plus offset, flags unchanged.
// [RL8] extended addressing is active only when the extended-set configuration bit is 1.
// [RL9] each instruction takes one instruction cycle of four phases: decode, read, process, write.
`ifndef ILO_PARAMS_SVH
`define ILO_PARAMS_SVH

// ----------------------------------------
// opcode fields, offset limit and set-all value
// ----------------------------------------
`define ILO_OP_ADD_HI    6'h09
`define ILO_OP_BITSET_HI 4'h8
`define ILO_OP_SETALL_HI 8'h68
`define ILO_IDX_LIMIT    8'h5F
`define ILO_ALL_ONES     8'hFF

// ----------------------------------------
// reset values
// ----------------------------------------
`define ILO_W_RST        8'h00
`define ILO_PTR_RST      12'h000
`define ILO_STATUS_RST   5'h00

`endif

// File: verilog/ilo_pkg.sv
/*
 types of the indexed literal offset executor.
 assumes ilo_params.svh is on the include path.
*/
package ilo_pkg;

	typedef enum logic [1:0]
	{
		PH_DECODE  = 2'b00,
		PH_READ    = 2'b01,
		PH_PROCESS = 2'b10,
		PH_WRITE   = 2'b11
	} phase_t;

	typedef enum logic [1:0]
	{
		OP_NONE = 2'b00,
		OP_ADD  = 2'b01,
		OP_BIT_SET = 2'b10,
		OP_SET_ALL = 2'b11
	} op_t;

	// negative, overflow, zero, digit carry, carry
	typedef struct packed
	{
		logic negative_flag;
		logic overflow_flag;
		logic zero_flag;
		logic digit_carry_flag;
		logic carry_flag;
	} status_t;

	typedef struct packed
	{
		logic        wr;
		logic        rd;
		logic [11:0] addr;
		logic [7:0]  wdata;
	} mem_req_t;

endpackage : ilo_pkg
